//--- hw/afr_regs.svh
// Constants for the amplifier fault and restart sequencer
`ifndef AFR_REGS_SVH
`define AFR_REGS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define AFR_ADDR_W          8
`define AFR_REG_CTRL        8'h00
`define AFR_REG_STATUS      8'h04
`define AFR_REG_FAULT_LOG   8'h08
`define AFR_REG_RETRY_CNT   8'h0C

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define AFR_CTRL_EN_BIT     0
`define AFR_CTRL_RESET      1'h0
`define AFR_STAT_STATE_LSB  0
`define AFR_STAT_PWR_LSB    3
`define AFR_STAT_DISCH_BIT  5
`define AFR_STAT_SUPF_BIT   6
`define AFR_STAT_SHORT_BIT  7
`define AFR_LOG_W           5
`define AFR_LOG_OC_BIT      0
`define AFR_LOG_UV_BIT      1
`define AFR_LOG_OV_BIT      2
`define AFR_LOG_UB_BIT      3
`define AFR_LOG_SHORT_BIT   4
`define AFR_LOG_RESET       5'h00
`define AFR_RETRY_W         8
`define AFR_RETRY_RESET     8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define AFR_CLK_KHZ         125000
`define AFR_RESTART_MS      100
`define AFR_SWITCH_KHZ      345
`define AFR_TMR_W           24
`define AFR_DIV_W           9
`define AFR_SYNC_W          10

`endif

//--- hw/afr_pkg.sv
// Types shared by the amplifier fault and restart sequencer
package afr_pkg;

	typedef enum logic [2:0] {
		AFR_ST_STANDBY     = 3'h0,
		AFR_ST_WINDOW      = 3'h1,
		AFR_ST_RUN         = 3'h2,
		AFR_ST_OC_WAIT     = 3'h3,
		AFR_ST_SUPPLY_WAIT = 3'h4
	} afr_state_t;

	typedef enum logic [2:0] {
		AFR_SEL_NONE   = 3'h0,
		AFR_SEL_CTRL   = 3'h1,
		AFR_SEL_STATUS = 3'h2,
		AFR_SEL_LOG    = 3'h3,
		AFR_SEL_RETRY  = 3'h4
	} afr_sel_t;

endpackage : afr_pkg

//--- hw/afr_sync.sv
// Two-stage synchroniser for the analog comparator inputs
`timescale 1ns/100ps
`include "afr_regs.svh"

module afr_sync (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic [`AFR_SYNC_W-1:0] async_in,
	output logic      [`AFR_SYNC_W-1:0] sync_out
);

	logic [`AFR_SYNC_W-1:0] meta;

	// ----------------------------------------------------------------
	// One pair of flops per comparator
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < `AFR_SYNC_W; i++) begin : g_bit
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta[i]     <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					meta[i]     <= async_in[i];
					sync_out[i] <= meta[i];
				end
			end
		end
	endgenerate

endmodule : afr_sync

//--- hw/afr_timer.sv
// Shared restart delay timer
`timescale 1ns/100ps
`include "afr_regs.svh"

module afr_timer #(
	parameter int CYCLES = `AFR_RESTART_MS * `AFR_CLK_KHZ
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic hold,
	output logic      done
);

	logic [`AFR_TMR_W-1:0] count;
	logic                  hit;

	assign hit = (count == `AFR_TMR_W'(CYCLES - 1));

	// ----------------------------------------------------------------
	// Count while released, restart from zero on every hold
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (hold || hit) begin
			count <= '0;
		end else begin
			count <= count + `AFR_TMR_W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done <= 1'b0;
		end else begin
			done <= !hold && hit;
		end
	end

endmodule : afr_timer

//--- hw/afr_sequencer.sv
// Fault handling and restart sequencer for a two-channel class-D stage
//
// Contract
// - Overcurrent turns that output's switches off
// - Re-enable next switching cycle, cut again if needed
// - Empty protect capacitor forces complete shutdown
// - Retry switch-on every 100 ms
// - No overcurrent at retry: stay operating
// - Startup short check halts until short removed
// - Short check passes before stages enabled
// - Each retry reruns the short check
// - Undervoltage shuts down, restarts 100 ms later
// - Overvoltage shuts down, restarts 100 ms later
// - Rail unbalance triggers shutdown
// - Unbalance cleared: restart after 100 ms
// - Discharge protect capacitor during overcurrent
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
`include "afr_regs.svh"

module afr_sequencer #(
	parameter int RESTART_CYCLES = `AFR_RESTART_MS * `AFR_CLK_KHZ
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`AFR_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic [1:0]             overcurrent_guard,
	input  wire logic [1:0]             short_positive_power_rail,
	input  wire logic [1:0]             short_negative_power_rail,
	input  wire logic                   prot_empty,
	input  wire logic                   undervoltage,
	input  wire logic                   overvoltage,
	input  wire logic                   rail_unbalance,
	output logic      [1:0]             power_en,
	output logic                        prot_discharge,
	output logic                        short_check,
	output afr_pkg::afr_state_t         seq_state
);
	import afr_pkg::*;

	localparam int SWITCH_CYCLES = `AFR_CLK_KHZ / `AFR_SWITCH_KHZ;

	// ----------------------------------------------------------------
	// Comparator synchronisation
	// ----------------------------------------------------------------
	logic [`AFR_SYNC_W-1:0] sync_bus;
	logic [1:0]             oc_s;
	logic [1:0]             shp_s;
	logic [1:0]             shn_s;
	logic                   prot_empty_s;
	logic                   uv_s;
	logic                   ov_s;
	logic                   ub_s;

	afr_sync u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({overcurrent_guard, short_positive_power_rail,
		            short_negative_power_rail, prot_empty,
		            undervoltage, overvoltage, rail_unbalance}),
		.sync_out (sync_bus)
	);

	assign {oc_s, shp_s, shn_s, prot_empty_s, uv_s, ov_s, ub_s} = sync_bus;

	logic supply_fault;
	logic short_any;

	assign supply_fault = uv_s || ov_s || ub_s;
	assign short_any    = |{shp_s, shn_s};

	// ----------------------------------------------------------------
	// Switching cycle enable
	// ----------------------------------------------------------------
	logic [`AFR_DIV_W-1:0] div_cnt;
	logic                  cycle_start;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt     <= '0;
			cycle_start <= 1'b0;
		end else if (div_cnt == `AFR_DIV_W'(SWITCH_CYCLES - 1)) begin
			div_cnt     <= '0;
			cycle_start <= 1'b1;
		end else begin
			div_cnt     <= div_cnt + `AFR_DIV_W'(1);
			cycle_start <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Restart timer
	// ----------------------------------------------------------------
	logic timer_hold;
	logic timer_done;
	logic ctrl_en;

	// delay counts only after last fault clears
	assign timer_hold = supply_fault ||
	                    !(seq_state == AFR_ST_OC_WAIT || seq_state == AFR_ST_SUPPLY_WAIT);

	// one timer for every restart delay
	afr_timer #(
		.CYCLES (RESTART_CYCLES)
	) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.hold    (timer_hold),
		.done    (timer_done)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	afr_state_t next_state;

	always_comb begin
		next_state = seq_state;
		if (!ctrl_en) begin
			next_state = AFR_ST_STANDBY;
		end else if (supply_fault) begin
			next_state = AFR_ST_SUPPLY_WAIT;
		end else begin
			case (seq_state)
				AFR_ST_STANDBY: begin
					next_state = AFR_ST_WINDOW;
				end
				AFR_ST_WINDOW: begin
					next_state = short_any ? AFR_ST_WINDOW : AFR_ST_RUN;
				end
				AFR_ST_RUN: begin
					next_state = prot_empty_s ? AFR_ST_OC_WAIT : AFR_ST_RUN;
				end
				AFR_ST_OC_WAIT: begin
					next_state = timer_done ? AFR_ST_WINDOW : AFR_ST_OC_WAIT;
				end
				AFR_ST_SUPPLY_WAIT: begin
					next_state = timer_done ? AFR_ST_WINDOW : AFR_ST_SUPPLY_WAIT;
				end
				default: begin
					next_state = AFR_ST_STANDBY;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_state <= AFR_ST_STANDBY;
		end else begin
			seq_state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Cycle-by-cycle cut-off and stage gating
	// ----------------------------------------------------------------
	logic [1:0] cut;
	logic [1:0] next_cut;

	// overcurrent wins over the cycle release
	assign next_cut = oc_s | (cut & ~{2{cycle_start}});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cut <= 2'h0;
		end else begin
			cut <= next_cut;
		end
	end

	// stages only run after the check
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_en <= 2'h0;
		end else begin
			power_en <= {2{next_state == AFR_ST_RUN}} & ~next_cut;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prot_discharge <= 1'b0;
		end else begin
			prot_discharge <= (next_state == AFR_ST_RUN) && (|oc_s);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			short_check <= 1'b0;
		end else begin
			short_check <= (next_state == AFR_ST_WINDOW);
		end
	end

	// ----------------------------------------------------------------
	// Event log and retry count
	// ----------------------------------------------------------------
	logic [`AFR_LOG_W-1:0]   fault_log;
	logic [`AFR_LOG_W-1:0]   log_set;
	logic [`AFR_LOG_W-1:0]   log_clr;
	logic [`AFR_RETRY_W-1:0] retry_cnt;
	logic                    wr_access;
	afr_sel_t                sel;

	always_comb begin
		log_set                     = '0;
		log_set[`AFR_LOG_OC_BIT]    = (seq_state == AFR_ST_RUN) &&
		                              (next_state == AFR_ST_OC_WAIT);
		log_set[`AFR_LOG_UV_BIT]    = uv_s;
		log_set[`AFR_LOG_OV_BIT]    = ov_s;
		log_set[`AFR_LOG_UB_BIT]    = ub_s;
		log_set[`AFR_LOG_SHORT_BIT] = (seq_state == AFR_ST_WINDOW) && short_any;
	end

	assign log_clr = (wr_access && sel == AFR_SEL_LOG) ? pwdata[`AFR_LOG_W-1:0] : '0;

	// Set beats a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_log <= `AFR_LOG_RESET;
		end else begin
			fault_log <= (fault_log & ~log_clr) | log_set;
		end
	end

	// count each 100 ms retry attempt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			retry_cnt <= `AFR_RETRY_RESET;
		end else if (seq_state == AFR_ST_OC_WAIT && next_state == AFR_ST_WINDOW) begin
			retry_cnt <= retry_cnt + `AFR_RETRY_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// APB slave, no wait states, read data still come from a flop
	// ----------------------------------------------------------------
	function automatic afr_sel_t decode(input logic [`AFR_ADDR_W-1:0] addr);
		if (addr == `AFR_REG_CTRL) begin
			return AFR_SEL_CTRL;
		end else if (addr == `AFR_REG_STATUS) begin
			return AFR_SEL_STATUS;
		end else if (addr == `AFR_REG_FAULT_LOG) begin
			return AFR_SEL_LOG;
		end else if (addr == `AFR_REG_RETRY_CNT) begin
			return AFR_SEL_RETRY;
		end else begin
			return AFR_SEL_NONE;
		end
	endfunction : decode

	assign sel       = decode(paddr);
	assign wr_access = psel && penable && pready && pwrite && (sel != AFR_SEL_NONE);

	logic [31:0] status_word;
	logic [31:0] rd_word;

	always_comb begin
		status_word = '0;
		status_word[`AFR_STAT_STATE_LSB +: $bits(afr_state_t)] = seq_state;
		status_word[`AFR_STAT_PWR_LSB +: 2]                    = power_en;
		status_word[`AFR_STAT_DISCH_BIT]                       = prot_discharge;
		status_word[`AFR_STAT_SUPF_BIT]                        = supply_fault;
		status_word[`AFR_STAT_SHORT_BIT]                       = short_any;
		rd_word = '0;
		case (decode(paddr))
			AFR_SEL_CTRL:   rd_word[`AFR_CTRL_EN_BIT] = ctrl_en;
			AFR_SEL_STATUS: rd_word = status_word;
			AFR_SEL_LOG:    rd_word[`AFR_LOG_W-1:0] = fault_log;
			AFR_SEL_RETRY:  rd_word[`AFR_RETRY_W-1:0] = retry_cnt;
			default:        rd_word = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && (sel == AFR_SEL_NONE);
			prdata  <= (psel && !penable && !pwrite) ? rd_word : '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en <= `AFR_CTRL_RESET;
		end else if (wr_access && sel == AFR_SEL_CTRL) begin
			ctrl_en <= pwdata[`AFR_CTRL_EN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_running;
		seq_state == AFR_ST_RUN && next_state == AFR_ST_RUN;
	endsequence

	sequence s_clean_run;
		seq_state == AFR_ST_RUN && !prot_empty_s && !supply_fault && ctrl_en;
	endsequence

	cut_on_oc_a: assert property (oc_s[0] |=> !power_en[0])
		else $error("output stayed on during overcurrent");

	reenable_a: assert property (s_running ##0 (cycle_start && !oc_s[1]) |=> power_en[1])
		else $error("output not re-enabled at cycle start");

	shutdown_a: assert property (
		(seq_state == AFR_ST_RUN && prot_empty_s && ctrl_en && !supply_fault)
		|=> (seq_state == AFR_ST_OC_WAIT && power_en == 2'h0))
		else $error("no shutdown on empty protect capacitor");

	retry_a: assert property (
		(seq_state == AFR_ST_OC_WAIT && timer_done && ctrl_en && !supply_fault)
		|=> (seq_state == AFR_ST_WINDOW && short_check))
		else $error("retry did not start short check");

	stay_run_a: assert property (s_clean_run |=> seq_state == AFR_ST_RUN)
		else $error("left operating without a fault");

	window_hold_a: assert property (
		(seq_state == AFR_ST_WINDOW && short_any && ctrl_en && !supply_fault)
		|=> seq_state == AFR_ST_WINDOW)
		else $error("start-up resumed over a short");

	gate_off_a: assert property (seq_state != AFR_ST_RUN |-> power_en == 2'h0)
		else $error("stage enabled outside operation");

	discharge_a: assert property (s_running ##0 (|oc_s) |=> prot_discharge)
		else $error("capacitor not drained in overcurrent");

	supply_off_a: assert property (
		(supply_fault && ctrl_en) |=> (seq_state == AFR_ST_SUPPLY_WAIT) ##1 power_en == 2'h0)
		else $error("supply fault did not shut down");

	fault_hold_a: assert property (
		(seq_state == AFR_ST_SUPPLY_WAIT && supply_fault)
		|=> !timer_done [*2])
		else $error("restart timer ran during a fault");

endmodule : afr_sequencer

//--- testbench/afr_stage_model.sv
// Comparator and power switch model facing the fault sequencer
`timescale 1ns/100ps

module afr_stage_model #(
	parameter int CAP_FULL = 12,
	parameter int MIN_V    = 12,
	parameter int MAX_V    = 42
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [1:0] power_en,
	input  wire logic       prot_discharge,
	input  wire logic [1:0] load_fault,
	input  wire logic [1:0] short_pos,
	input  wire logic [1:0] short_neg,
	input  wire logic [7:0] pos_v,
	input  wire logic [7:0] neg_v,
	output logic      [1:0] overcurrent_guard,
	output logic      [1:0] short_positive_power_rail,
	output logic      [1:0] short_negative_power_rail,
	output logic            prot_empty,
	output logic            undervoltage,
	output logic            overvoltage,
	output logic            rail_unbalance
);
	int cap;
	int idle;

	// ----------------------------
	// Comparators
	// ----------------------------
	// Current only flows through switches that are on
	assign overcurrent_guard         = power_en & (load_fault | short_pos | short_neg);
	assign short_positive_power_rail = short_pos;
	assign short_negative_power_rail = short_neg;
	assign prot_empty                = (cap == 0);
	assign undervoltage              = (pos_v < MIN_V) || (neg_v < MIN_V);
	assign overvoltage               = (pos_v > MAX_V) || (neg_v > MAX_V);
	assign rail_unbalance            = (pos_v > 2 * neg_v) || (neg_v > 2 * pos_v);

	// ----------------------------
	// Protect capacitor
	// ----------------------------
	// Slow recharge, so repeated cut-offs drain it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap <= CAP_FULL;
			idle <= 0;
		end else if (prot_discharge) begin
			cap <= (cap > 0) ? cap - 1 : 0;
			idle <= 0;
		end else if (idle == 255) begin
			cap <= (cap < CAP_FULL) ? cap + 1 : cap;
			idle <= 0;
		end else begin
			idle <= idle + 1;
		end
	end
endmodule : afr_stage_model

//--- testbench/amp_fault_restart_sequencer_bench.sv
// Self-checking bench for the fault and restart sequencer
`timescale 1ns/100ps
`include "afr_regs.svh"

module amp_fault_restart_sequencer_bench;
	import afr_pkg::*;
	localparam int R = 50;
	typedef struct {int pos; int neg; logic [4:0] log;} afr_row_t;
	afr_row_t   rows [5] = '{'{11, 11, 5'h02}, '{45, 45, 5'h04}, '{35, 16, 5'h08},
	                         '{16, 35, 5'h08}, '{11, 25, 5'h0A}};
	logic [7:0] regs [3] = '{`AFR_REG_CTRL, `AFR_REG_FAULT_LOG, `AFR_REG_RETRY_CNT};
	logic       pclk, presetn, psel, penable, pwrite, pready, pslverr, err, seen;
	logic       prot_empty, undervoltage, overvoltage, rail_unbalance;
	logic       prot_discharge, short_check;
	logic [7:0] paddr, pos_v, neg_v;
	logic [31:0] pwdata, prdata, rd, r1;
	logic [1:0] overcurrent_guard, short_positive_power_rail, short_negative_power_rail;
	logic [1:0] power_en, load_fault, short_pos, short_neg;
	afr_state_t seq_state;
	int         n_mismatch, check_count, n;

	afr_sequencer #(.RESTART_CYCLES(R)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .overcurrent_guard(overcurrent_guard),
		.short_positive_power_rail(short_positive_power_rail),
		.short_negative_power_rail(short_negative_power_rail), .prot_empty(prot_empty),
		.undervoltage(undervoltage), .overvoltage(overvoltage), .rail_unbalance(rail_unbalance),
		.power_en(power_en), .prot_discharge(prot_discharge), .short_check(short_check),
		.seq_state(seq_state));

	afr_stage_model stage (.pclk(pclk), .presetn(presetn), .power_en(power_en),
		.prot_discharge(prot_discharge), .load_fault(load_fault), .short_pos(short_pos),
		.short_neg(short_neg), .pos_v(pos_v), .neg_v(neg_v),
		.overcurrent_guard(overcurrent_guard),
		.short_positive_power_rail(short_positive_power_rail),
		.short_negative_power_rail(short_negative_power_rail), .prot_empty(prot_empty),
		.undervoltage(undervoltage), .overvoltage(overvoltage), .rail_unbalance(rail_unbalance));

	initial pclk = 1'b0;
	always #4 pclk = ~pclk;

	// ----------------------------
	// Tasks
	// ----------------------------
	task finish_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask : chk

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			chk(1, 0, "bus timeout");
			finish_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wait_state(input afr_state_t s, input int lim);
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (seq_state !== s && n < lim);
		if (seq_state !== s) begin
			chk(seq_state, s, "state timeout");
			finish_test();
		end
	endtask : wait_state

	// Waits for output 0 to reach a level, noting any discharge
	task wait_en(input logic v, input int lim);
		n = 0;
		do begin
			@(negedge pclk);
			n++;
			seen |= prot_discharge;
		end while (power_en[0] !== v && n < lim);
		if (power_en[0] !== v) begin
			chk(power_en[0], v, "enable timeout");
			finish_test();
		end
	endtask : wait_en

	// ----------------------------
	// Sequence
	// ----------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn, load_fault, short_pos, short_neg} = '0;
		pos_v = 8'h23;
		neg_v = 8'h23;
		seen = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk({seq_state, power_en, prot_discharge, short_check}, 0, "reset outputs");
		foreach (regs[i]) begin
			apb(1'b0, regs[i], 32'h0);
			chk(rd, 32'h0, "register reset");
		end
		apb(1'b0, 8'h10, 32'h0);
		chk(err, 1, "unmapped error");
		short_pos <= 2'b10;
		apb(1'b1, `AFR_REG_CTRL, 32'h1);
		wait_state(AFR_ST_WINDOW, 10);
		repeat (30) @(negedge pclk);
		chk(seq_state, AFR_ST_WINDOW, "start held");
		chk({power_en, short_check}, 3'h1, "stages off in check");
		apb(1'b0, `AFR_REG_STATUS, 32'h0);
		chk(rd, 32'h81, "status in check");
		@(posedge pclk);
		short_pos <= 2'b00;
		wait_state(AFR_ST_RUN, 20);
		chk(power_en, 2'h3, "start resumed");
		apb(1'b0, `AFR_REG_FAULT_LOG, 32'h0);
		chk(rd, 32'h10, "short logged");
		apb(1'b1, `AFR_REG_FAULT_LOG, 32'h1F);
		foreach (rows[i]) begin
			@(posedge pclk);
			pos_v <= rows[i].pos[7:0];
			neg_v <= rows[i].neg[7:0];
			repeat (6) @(negedge pclk);
			chk({seq_state, power_en}, {AFR_ST_SUPPLY_WAIT, 2'h0}, "supply off");
			apb(1'b0, `AFR_REG_STATUS, 32'h0);
			chk(rd, 32'h44, "status in supply wait");
			@(posedge pclk);
			pos_v <= 8'h23;
			neg_v <= 8'h23;
			wait_state(AFR_ST_RUN, R + 40);
			chk(n >= R && n <= R + 10, 1, "supply delay");
			apb(1'b0, `AFR_REG_FAULT_LOG, 32'h0);
			chk(rd, rows[i].log, "fault log");
			apb(1'b1, `AFR_REG_FAULT_LOG, 32'h1F);
		end
		@(posedge pclk);
		pos_v <= 8'd11;
		neg_v <= 8'd25;
		repeat (6) @(negedge pclk);
		@(posedge pclk);
		pos_v <= 8'd13;
		neg_v <= 8'd30;
		repeat (R + 20) @(negedge pclk);
		chk(seq_state, AFR_ST_SUPPLY_WAIT, "held by second fault");
		@(posedge pclk);
		pos_v <= 8'h23;
		neg_v <= 8'h23;
		wait_state(AFR_ST_RUN, R + 40);
		chk(n >= R && n <= R + 10, 1, "delay from last clear");
		apb(1'b1, `AFR_REG_FAULT_LOG, 32'h1F);
		@(posedge pclk);
		load_fault <= 2'b01;
		wait_en(1'b0, 10);
		chk(power_en, 2'h2, "cut affected output");
		wait_en(1'b1, 400);
		chk(n < 400, 1, "back next cycle");
		wait_en(1'b0, 10);
		chk(n < 10, 1, "cut again");
		chk(seen, 1, "capacitor drained");
		wait_state(AFR_ST_OC_WAIT, 8000);
		chk(power_en, 2'h0, "complete shutdown");
		wait_state(AFR_ST_WINDOW, R + 40);
		chk(n >= R && n <= R + 10, 1, "retry delay");
		wait_state(AFR_ST_OC_WAIT, 100);
		repeat (10) @(negedge pclk);
		apb(1'b0, `AFR_REG_RETRY_CNT, 32'h0);
		r1 = rd;
		apb(1'b0, `AFR_REG_FAULT_LOG, 32'h0);
		chk(rd, 32'h1, "shutdown logged");
		wait_state(AFR_ST_WINDOW, R + 40);
		wait_state(AFR_ST_OC_WAIT, 100);
		repeat (10) @(negedge pclk);
		apb(1'b0, `AFR_REG_RETRY_CNT, 32'h0);
		chk(rd, {24'h0, r1[7:0] + 8'h1}, "retry repeated");
		@(posedge pclk);
		load_fault <= 2'b00;
		short_neg <= 2'b01;
		wait_state(AFR_ST_WINDOW, R + 40);
		repeat (600) @(negedge pclk);
		chk({seq_state, power_en}, {AFR_ST_WINDOW, 2'h0}, "retry held by short");
		@(posedge pclk);
		short_neg <= 2'b00;
		wait_state(AFR_ST_RUN, 20);
		repeat (3 * R) @(negedge pclk);
		chk({seq_state, power_en}, {AFR_ST_RUN, 2'h3}, "stays operating");
		apb(1'b1, `AFR_REG_CTRL, 32'h0);
		repeat (2) @(negedge pclk);
		chk({seq_state, power_en, short_check}, {AFR_ST_STANDBY, 3'h0}, "disabled");
		finish_test();
	end
endmodule : amp_fault_restart_sequencer_bench
